// ==== pkg/sirb_pkg.sv ====
// Constants shared by the status register bank and its pin watcher
package sirb_pkg;
   // Register bus widths, pin count and synchroniser depth
   localparam int ADDR_W = 9;
   localparam int DATA_W = 8;
   localparam int PIN_CNT = 4;
   localparam int SYNC_STAGES = 2;

   // Register addresses
   localparam logic [8:0] ADDR_PART_HI = 9'h030;
   localparam logic [8:0] ADDR_PART_LO = 9'h031;
   localparam logic [8:0] ADDR_CFG     = 9'h040;
   localparam logic [8:0] ADDR_PIN     = 9'h041;
   localparam logic [8:0] ADDR_IRQ     = 9'h042;
   localparam logic [8:0] ADDR_BOOT    = 9'h043;
   localparam logic [8:0] STATUS_BASE  = 9'h040;

   // Configuration status fields
   localparam int CFG_WRITTEN_BIT = 7;
   localparam int CFG_PORT_LSB    = 4;
   localparam int CFG_FACTORY_BIT = 3;
   localparam int CFG_IMAGE_LSB   = 0;

   // Pin state and change fields
   localparam int PIN_FLAG_LSB  = 4;
   localparam int PIN_STATE_LSB = 0;

   // Interrupt summary fields
   localparam int IRQ_SUMMARY_BIT = 5;
   localparam int IRQ_GATE_BIT    = 1;
   localparam int IRQ_FLAG_BIT    = 0;

   // Boot done and pin enable fields
   localparam int BOOT_DONE_BIT = 7;
   localparam int BOOT_EN_LSB   = 0;

   // Follow selection layout: register in 7:3, bit in 2:0
   localparam int FOLLOW_REG_LSB = 3;
   localparam int FOLLOW_SEL_W   = 8;

   // Values after reset
   localparam logic       RST_GATE  = 1'b0;
   localparam logic [3:0] RST_EN    = 4'h0;
   localparam logic [3:0] RST_FLAGS = 4'h0;
   localparam logic [1:0] RST_PORT  = 2'h0;
   localparam logic [2:0] RST_IMAGE = 3'h0;
   localparam logic [7:0] RD_NONE   = 8'h00;
endpackage : sirb_pkg

// ==== pkg/sirb_pin_if.sv ====
// Synchronised pin levels and change pulses between watcher and bank
`timescale 1ns/10ps
interface sirb_pin_if;
   logic [3:0] level;
   logic [3:0] change;

   // Watcher drives, bank listens
   modport watch (output level, output change);
   modport bank  (input level, input change);
endinterface : sirb_pin_if

// ==== rtl/sirb_pin_watch.sv ====
// Pin synchroniser and transition detector for the multi-purpose pins
`timescale 1ns/10ps
module sirb_pin_watch #(
   parameter int NUM_PINS = 4
) (
   // Clock and reset
   input  wire logic                clk_i,
   input  wire logic                reset_n_i,
   // Raw pins
   input  wire logic [NUM_PINS-1:0] pin_i,
   // Toward the bank
   sirb_pin_if.watch                pw
);
   // Bank fields are four bits wide
   if (NUM_PINS != sirb_pkg::PIN_CNT) begin : g_bad
      $error("sirb_pin_watch: NUM_PINS must be 4");
   end

   logic [NUM_PINS-1:0] meta;
   logic [NUM_PINS-1:0] sync;
   logic [NUM_PINS-1:0] prev;
   logic                armed;

   // No reset on the synchroniser so straps are valid at release
   genvar i;
   for (i = 0; i < NUM_PINS; i++) begin : g_pin
      always_ff @(posedge clk_i) begin
         meta[i] <= pin_i[i];
         sync[i] <= meta[i];
         prev[i] <= sync[i];
      end
      // Change pulse only once prev holds a real sample
      always_ff @(posedge clk_i) begin
         if (!reset_n_i) begin
            pw.change[i] <= 1'b0;
         end else begin
            pw.change[i] <= armed & (sync[i] ^ prev[i]);
         end
      end
   end

   // Arming avoids a false edge right after reset
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         armed <= 1'b0;
      end else begin
         armed <= 1'b1;
      end
   end

   // Raw level, no inversion applied
   assign pw.level = sync;
endmodule : sirb_pin_watch

// ==== rtl/sirb_status_bank.sv ====
// Status and interrupt register bank of the clock fanout buffer
// Behaviour
// - 12-bit part code split over two identification registers, read-only.
// - Low nibble of second identification register is silicon version from 0.
// - Written flag clears on any reset, sets on any register write.
// - Host port strap captures interface-select pins when reset pin rises.
// - Factory check strap captured at reset release or hard reset release.
// - Boot image strap captured at reset release or hard reset release.
// - Change flag sets on any pin transition, cleared by writing one.
// - Set change flag requests interrupt only while its enable is one.
// - Pin state bits report raw pin level, ignoring inversion.
// - Output clock summary is one when any output interrupt status set.
// - Master gate at zero keeps every source off the global flag.
// - Global flag set by gated summary or enabled pin change flags.
// - No interrupt pin; global flag leaves via the irq_global_o copy or a following pin.
// - Boot finished clears on reset, sets when boot controller completes.
// - During boot the controller owns the bus; host access has no effect.
// - Boot script setup 0x04 and 00011111b makes pin follow boot finished.
// - Following pin shows bit of register 0x40 plus selection, only for 0x40, 0x42 and 0x43; else zero.
`timescale 1ns/10ps
module sirb_status_bank #(
   parameter logic [11:0] PART_CODE       = 12'hA5C, // Arbitrary value
   parameter logic [3:0]  SILICON_VERSION = 4'h0
) (
   // Clock and reset pin
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   // Reset control bits
   input  wire logic        hard_reset_i,
   input  wire logic        soft_reset_i,
   // Pins
   input  wire logic [3:0]  pin_i,
   input  wire logic [1:0]  port_sel_pin_i,
   // Host register port
   input  wire logic        host_wr_i,
   input  wire logic        host_rd_i,
   input  wire logic [8:0]  host_addr_i,
   input  wire logic [7:0]  host_wdata_i,
   output logic [7:0]       host_rdata_o,
   output logic             host_rvalid_o,
   // Boot controller port
   input  wire logic        boot_busy_i,
   input  wire logic        boot_wr_i,
   input  wire logic [8:0]  boot_addr_i,
   input  wire logic [7:0]  boot_wdata_i,
   input  wire logic        boot_done_i,
   // Output clock interrupt status
   input  wire logic [7:0]  out_clk_irq_status1_i,
   // Status follow setup per pin
   input  wire logic [3:0]  pin_follow_en_i,
   input  wire logic [31:0] pin_follow_sel_i,
   // Status outputs
   output logic [3:0]       pin_status_o,
   output logic             irq_global_o
);
   sirb_pin_if pw ();

   sirb_pin_watch #(
      .NUM_PINS (sirb_pkg::PIN_CNT)
   ) u_watch (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .pin_i     (pin_i),
      .pw        (pw.watch)
   );

   logic [1:0] port_meta;
   logic [1:0] port_sync;
   logic       pin_rst_d;
   logic       hard_d;
   logic       written_since_reset;
   logic [1:0] host_port_strap;
   logic       factory_check_strap;
   logic [2:0] boot_image_select_strap;
   logic [3:0] change_flag;
   logic [3:0] change_irq_en;
   logic       irq_master_gate;
   logic       irq_global_flag;
   logic       boot_finished;
   logic       out_clk_irq_summary;
   logic       dev_rst;
   logic       pin_rise;
   logic       hard_fall;
   logic       eff_wr;
   logic [8:0] eff_addr;
   logic [7:0] eff_wdata;
   logic [3:0] flag_clr;
   logic       next_irq_flag;

   // Interface-select pins, free running for strap capture
   always_ff @(posedge clk_i) begin
      port_meta <= port_sel_pin_i;
      port_sync <= port_meta;
   end

   // Release edges of the reset pin and the hard reset bit
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         pin_rst_d <= 1'b0;
         hard_d    <= 1'b0;
      end else begin
         pin_rst_d <= 1'b1;
         hard_d    <= hard_reset_i;
      end
   end

   assign pin_rise  = reset_n_i & ~pin_rst_d;
   assign hard_fall = hard_d & ~hard_reset_i;
   assign dev_rst   = hard_reset_i | soft_reset_i;

   // Boot controller owns the bus; host writes dropped meanwhile
   assign eff_wr    = boot_busy_i ? boot_wr_i : host_wr_i;
   assign eff_addr  = boot_busy_i ? boot_addr_i : host_addr_i;
   assign eff_wdata = boot_busy_i ? boot_wdata_i : host_wdata_i;

   // Written flag; a write in a reset cycle loses to the reset
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         written_since_reset <= 1'b0;
      end else if (dev_rst) begin
         written_since_reset <= 1'b0;
      end else if (eff_wr) begin
         written_since_reset <= 1'b1;
      end
   end

   // Host port strap only follows the pin, not the control bits
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         host_port_strap <= sirb_pkg::RST_PORT;
      end else if (pin_rise) begin
         host_port_strap <= port_sync;
      end
   end

   // Shared pins also recaptured when hard reset lets go
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         factory_check_strap     <= 1'b0;
         boot_image_select_strap <= sirb_pkg::RST_IMAGE;
      end else if (pin_rise || hard_fall) begin
         factory_check_strap     <= pw.level[3];
         boot_image_select_strap <= pw.level[2:0];
      end
   end

   // Write-one-to-clear; a new transition beats the clear
   always_comb begin
      flag_clr = 4'h0;
      if (eff_wr && eff_addr == sirb_pkg::ADDR_PIN) begin
         flag_clr = eff_wdata[sirb_pkg::PIN_FLAG_LSB +: 4];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i || dev_rst) begin
         change_flag <= sirb_pkg::RST_FLAGS;
      end else begin
         change_flag <= (change_flag & ~flag_clr) | pw.change;
      end
   end

   // Writable gate and per-pin enables; reserved bits dropped
   always_ff @(posedge clk_i) begin
      if (!reset_n_i || dev_rst) begin
         irq_master_gate <= sirb_pkg::RST_GATE;
         change_irq_en   <= sirb_pkg::RST_EN;
      end else if (eff_wr) begin
         if (eff_addr == sirb_pkg::ADDR_IRQ) begin
            irq_master_gate <= eff_wdata[sirb_pkg::IRQ_GATE_BIT];
         end
         if (eff_addr == sirb_pkg::ADDR_BOOT) begin
            change_irq_en <= eff_wdata[sirb_pkg::BOOT_EN_LSB +: 4];
         end
      end
   end

   // Boot finished held until the next device reset
   always_ff @(posedge clk_i) begin
      if (!reset_n_i || dev_rst) begin
         boot_finished <= 1'b0;
      end else if (boot_done_i) begin
         boot_finished <= 1'b1;
      end
   end

   // Summary is live; gate covers pin sources too
   assign out_clk_irq_summary = |out_clk_irq_status1_i;
   assign next_irq_flag = irq_master_gate &
                          (out_clk_irq_summary |
                           |(change_flag & change_irq_en));

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         irq_global_flag <= 1'b0;
      end else begin
         irq_global_flag <= next_irq_flag;
      end
   end

   // Word at an address; unmapped and reserved bits read zero
   function automatic logic [7:0] bank_word(input logic [8:0] a);
      logic [7:0] w;
      w = sirb_pkg::RD_NONE;
      case (a)
         sirb_pkg::ADDR_PART_HI: w = PART_CODE[11:4];
         sirb_pkg::ADDR_PART_LO: w = {PART_CODE[3:0],
                                      SILICON_VERSION};
         sirb_pkg::ADDR_CFG: begin
            w[sirb_pkg::CFG_WRITTEN_BIT]     = written_since_reset;
            w[sirb_pkg::CFG_PORT_LSB +: 2]   = host_port_strap;
            w[sirb_pkg::CFG_FACTORY_BIT]     = factory_check_strap;
            w[sirb_pkg::CFG_IMAGE_LSB +: 3]  = boot_image_select_strap;
         end
         sirb_pkg::ADDR_PIN: begin
            w[sirb_pkg::PIN_FLAG_LSB +: 4]  = change_flag;
            w[sirb_pkg::PIN_STATE_LSB +: 4] = pw.level;
         end
         sirb_pkg::ADDR_IRQ: begin
            w[sirb_pkg::IRQ_SUMMARY_BIT] = out_clk_irq_summary;
            w[sirb_pkg::IRQ_GATE_BIT]    = irq_master_gate;
            w[sirb_pkg::IRQ_FLAG_BIT]    = irq_global_flag;
         end
         sirb_pkg::ADDR_BOOT: begin
            w[sirb_pkg::BOOT_DONE_BIT]     = boot_finished;
            w[sirb_pkg::BOOT_EN_LSB +: 4]  = change_irq_en;
         end
         default: w = sirb_pkg::RD_NONE;
      endcase
      return w;
   endfunction : bank_word

   // Host read answers next cycle; zero while boot holds the bus
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         host_rdata_o  <= sirb_pkg::RD_NONE;
         host_rvalid_o <= 1'b0;
      end else begin
         host_rvalid_o <= host_rd_i;
         if (host_rd_i && !boot_busy_i) begin
            host_rdata_o <= bank_word(host_addr_i);
         end else begin
            host_rdata_o <= sirb_pkg::RD_NONE;
         end
      end
   end

   // Status follow per pin; pin state register may not be followed
   genvar p;
   for (p = 0; p < sirb_pkg::PIN_CNT; p++) begin : g_follow
      logic [7:0] sel;
      logic [8:0] tgt;
      logic       next_level;
      assign sel = pin_follow_sel_i[p*8 +: 8];
      assign tgt = sirb_pkg::STATUS_BASE +
                   {4'h0, sel[7:sirb_pkg::FOLLOW_REG_LSB]};
      always_comb begin
         next_level = 1'b0;
         if (pin_follow_en_i[p] && (tgt == sirb_pkg::ADDR_CFG ||
             tgt == sirb_pkg::ADDR_IRQ || tgt == sirb_pkg::ADDR_BOOT)) begin
            next_level = |(bank_word(tgt) & (8'h01 << sel[2:0]));
         end
      end
      always_ff @(posedge clk_i) begin
         if (!reset_n_i) begin
            pin_status_o[p] <= 1'b0;
         end else begin
            pin_status_o[p] <= next_level;
         end
      end
   end

   // Global flag copy for a pin driver; no dedicated pin
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         irq_global_o <= 1'b0;
      end else begin
         irq_global_o <= next_irq_flag;
      end
   end

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   sequence s_host_read(logic [8:0] a);
      host_rd_i && !boot_busy_i && host_addr_i == a;
   endsequence

   sequence s_boot_end;
      boot_done_i && !dev_rst ##1 !dev_rst [*2];
   endsequence

   a_part_code_hi: assert property (
      s_host_read(sirb_pkg::ADDR_PART_HI) |=>
         host_rvalid_o && host_rdata_o == PART_CODE[11:4])
      else $error("part code high wrong");

   a_version_read: assert property (
      s_host_read(sirb_pkg::ADDR_PART_LO) |=>
         host_rdata_o == {PART_CODE[3:0], SILICON_VERSION})
      else $error("part code low or version wrong");

   a_written_set: assert property (
      eff_wr && !dev_rst ##1 !dev_rst |=> written_since_reset)
      else $error("written flag did not set");

   a_written_clear: assert property (
      dev_rst |=> !written_since_reset)
      else $error("written flag not cleared");

   a_port_strap: assert property (
      !pin_rise && !$past(pin_rise) |-> $stable(host_port_strap))
      else $error("port strap changed after capture");

   a_image_strap: assert property (
      hard_fall |=> boot_image_select_strap == $past(pw.level[2:0]))
      else $error("image strap not captured");

   a_factory_strap: assert property (
      hard_fall |=> factory_check_strap == $past(pw.level[3]))
      else $error("factory strap not captured");

   a_flag_set: assert property (
      (|pw.change) && !dev_rst |=>
         (change_flag & $past(pw.change)) == $past(pw.change))
      else $error("change flag missed a transition");

   a_flag_hold: assert property (
      !dev_rst && flag_clr == 4'h0 |=>
         (change_flag & $past(change_flag)) == $past(change_flag))
      else $error("change flag dropped without clear");

   a_pin_state: assert property (
      s_host_read(sirb_pkg::ADDR_PIN) |=>
         host_rdata_o[3:0] == $past(pw.level))
      else $error("pin state read wrong");

   a_gate_block: assert property (
      !irq_master_gate |=> !irq_global_flag && !irq_global_o)
      else $error("gate closed but flag set");

   a_pin_irq: assert property (
      irq_master_gate && |(change_flag & change_irq_en) |=>
         irq_global_flag)
      else $error("enabled pin change gave no flag");

   a_summary_irq: assert property (
      irq_master_gate && out_clk_irq_summary |=> irq_global_flag)
      else $error("summary gave no flag");

   a_boot_owns: assert property (
      boot_busy_i && !boot_wr_i && !dev_rst |=>
         $stable(irq_master_gate) && $stable(change_irq_en))
      else $error("host write took effect during boot");

   a_boot_done: assert property (
      s_boot_end |-> boot_finished)
      else $error("boot finished not held");

   a_follow_boot: assert property (
      pin_follow_en_i[0] && pin_follow_sel_i[7:0] == 8'h1F |=>
         pin_status_o[0] == $past(boot_finished))
      else $error("pin did not follow boot finished");

   a_follow_none: assert property (
      !pin_follow_en_i[1] |=> !pin_status_o[1])
      else $error("pin driven while not following");
endmodule : sirb_status_bank

// ==== sim/sirb_host_model.sv ====
// Host processor model issuing register cycles to the status bank
`timescale 1ns/10ps
module sirb_host_model (
   // Clock
   input  wire logic       clk_i,
   // Register port toward the bank
   output logic            wr_o,
   output logic            rd_o,
   output logic [8:0]      addr_o,
   output logic [7:0]      wdata_o
);
   // Idle bus starts quiet
   initial begin
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = 9'h000;
      wdata_o = 8'h00;
   end

   // One strobe cycle; idle bus shows inverted values so stale data fails
   task automatic access(input logic w, input logic [8:0] a,
                         input logic [7:0] d);
      @(negedge clk_i);
      wr_o = w;
      rd_o = ~w;
      addr_o = a;
      wdata_o = d;
      @(negedge clk_i);
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
   endtask : access
endmodule : sirb_host_model

// ==== sim/test_status_and_irq_registers.sv ====
// Self-checking bench for the status and interrupt register bank
`timescale 1ns/10ps
module test_status_and_irq_registers;
   localparam logic [11:0] PC  = 12'h6B3; // Arbitrary part code
   localparam logic [3:0]  VER = 4'h3;
   typedef struct {string name; logic [7:0] exp;} sirb_note_t;

   logic        clk_i = 1'b0;
   logic        reset_n_i = 1'b0;
   logic        hard_rst = 1'b0;
   logic        soft_rst = 1'b0;
   logic [3:0]  pin_lvl = 4'b0101;
   logic [1:0]  port_sel = 2'b10;
   logic        wr, rd;
   logic [8:0]  addr;
   logic [7:0]  wdata, rdata;
   logic        rvalid;
   logic        boot_busy = 1'b0;
   logic        boot_wr = 1'b0;
   logic [8:0]  boot_addr = 9'h000;
   logic [7:0]  boot_wdata = 8'h00;
   logic        boot_done = 1'b0;
   logic [7:0]  oc_stat = 8'h00;
   logic [3:0]  follow_en = 4'h0;
   logic [31:0] follow_sel = 32'h0;
   logic [3:0]  pin_status;
   logic        irq_global;
   int          fail_count = 0;
   int          tests_run = 0;
   int          p;
   sirb_note_t  exp_q[$];

   // Free-running 50 MHz clock
   always #10 clk_i = ~clk_i;

   sirb_host_model u_host (.clk_i(clk_i), .wr_o(wr), .rd_o(rd),
      .addr_o(addr), .wdata_o(wdata));

   sirb_status_bank #(.PART_CODE(PC), .SILICON_VERSION(VER)) u_dut (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .hard_reset_i(hard_rst),
      .soft_reset_i(soft_rst), .pin_i(pin_lvl), .port_sel_pin_i(port_sel),
      .host_wr_i(wr), .host_rd_i(rd), .host_addr_i(addr),
      .host_wdata_i(wdata), .host_rdata_o(rdata), .host_rvalid_o(rvalid),
      .boot_busy_i(boot_busy), .boot_wr_i(boot_wr), .boot_addr_i(boot_addr),
      .boot_wdata_i(boot_wdata), .boot_done_i(boot_done),
      .out_clk_irq_status1_i(oc_stat), .pin_follow_en_i(follow_en),
      .pin_follow_sel_i(follow_sel), .pin_status_o(pin_status),
      .irq_global_o(irq_global));

   task automatic chk(input string name, input logic [7:0] exp,
                      input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic rdx(input string name, input logic [8:0] a,
                      input logic [7:0] e);
      exp_q.push_back('{name, e});
      u_host.access(1'b0, a, 8'h00);
   endtask : rdx

   task automatic wrx(input logic [8:0] a, input logic [7:0] d);
      u_host.access(1'b1, a, d);
   endtask : wrx

   task automatic idle(input int n);
      repeat (n) @(negedge clk_i);
   endtask : idle

   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : complete_run

   // Read answers are matched to the oldest outstanding note mid-cycle
   always @(negedge clk_i) begin
      if (rvalid === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk("unrequested read", 8'h00, 8'hFF);
         end else begin
            sirb_note_t n;
            n = exp_q.pop_front();
            chk(n.name, n.exp, rdata);
         end
      end
   end

   // Watchdog so a stuck handshake still reaches the verdict
   initial begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      complete_run();
   end

   // Main sequence
   initial begin
      void'($urandom(41));
      idle(10);
      reset_n_i = 1'b1;
      rdx("part_hi", 9'h030, PC[11:4]);
      rdx("part_lo", 9'h031, {PC[3:0], VER});
      rdx("cfg", 9'h040, 8'h25);
      rdx("pins", 9'h041, 8'h05);
      rdx("irq", 9'h042, 8'h00);
      rdx("boot", 9'h043, 8'h00);
      rdx("unmapped", 9'h050, 8'h00);
      wrx(9'h030, 8'hFF);
      wrx(9'h043, 8'hFF);
      rdx("part_hi_ro", 9'h030, PC[11:4]);
      rdx("enables", 9'h043, 8'h0F);
      rdx("written", 9'h040, 8'hA5);
      $display("test identity done");
      // Random pin toggles, gate closed first
      p = $urandom % 4;
      pin_lvl[p] = ~pin_lvl[p];
      idle(8);
      rdx("flag", 9'h041, {4'(1 << p), pin_lvl});
      rdx("gated", 9'h042, 8'h00);
      chk("irq_off", 8'h00, {7'h0, irq_global});
      wrx(9'h042, 8'h02);
      rdx("irq_on", 9'h042, 8'h03);
      chk("irq_out", 8'h01, {7'h0, irq_global});
      wrx(9'h043, 8'h00);
      rdx("en_off", 9'h042, 8'h02);
      wrx(9'h043, 8'h0F);
      wrx(9'h041, 8'hF0);
      rdx("cleared", 9'h041, {4'h0, pin_lvl});
      rdx("no_src", 9'h042, 8'h02);
      $display("test pin change done");
      oc_stat = 8'h01 << ($urandom % 8);
      idle(2);
      rdx("summary", 9'h042, 8'h23);
      // Pin 1 follows the global flag; pin 2 aims at pin state, refused
      follow_sel[15:8] = 8'h10;
      follow_sel[23:16] = {5'h01, (p == 0) ? 3'h2 : 3'h0};
      follow_en = 4'h6;
      idle(2);
      chk("irq_pin", 8'h02, {4'h0, pin_status});
      wrx(9'h042, 8'h00);
      rdx("sum_gated", 9'h042, 8'h20);
      chk("irq_pin_off", 8'h00, {4'h0, pin_status});
      oc_stat = 8'h00;
      $display("test summary done");
      // Soft reset, then a boot sequence with a following pin
      soft_rst = 1'b1;
      idle(1);
      soft_rst = 1'b0;
      rdx("soft_cfg", 9'h040, 8'h25);
      rdx("soft_boot", 9'h043, 8'h00);
      follow_en = 4'h1;
      follow_sel[7:0] = 8'h1F;
      boot_busy = 1'b1;
      boot_wr = 1'b1;
      boot_addr = 9'h043;
      boot_wdata = 8'h04;
      idle(1);
      boot_wr = 1'b0;
      wrx(9'h043, 8'h08);
      rdx("busy_rd", 9'h043, 8'h00);
      boot_busy = 1'b0;
      boot_done = 1'b1;
      idle(1);
      boot_done = 1'b0;
      idle(3);
      chk("follow", 8'h01, {4'h0, pin_status});
      rdx("booted", 9'h043, 8'h84);
      rdx("boot_cfg", 9'h040, 8'hA5);
      wrx(9'h043, 8'h8C);
      rdx("poll", 9'h043, 8'h84 | 8'h08);
      $display("test boot done");
      // Hard reset recaptures the shared-pin straps
      pin_lvl = 4'b0010;
      idle(8);
      hard_rst = 1'b1;
      idle(2);
      hard_rst = 1'b0;
      idle(3);
      rdx("hard_cfg", 9'h040, 8'h22);
      rdx("hard_pins", 9'h041, 8'h02);
      rdx("hard_boot", 9'h043, 8'h00);
      chk("follow_low", 8'h00, {4'h0, pin_status});
      $display("test hard reset done");
      for (int i = 0; i < 10 && exp_q.size() != 0; i++) begin
         idle(1);
      end
      if (exp_q.size() != 0) begin
         chk("pending reads", 8'h00, 8'(exp_q.size()));
      end
      complete_run();
   end
endmodule : test_status_and_irq_registers
